// >>> lfds_scheduler.sv
// module: duty-cycle scheduler for the wake-up receiver input detector, with APB registers
// Contract
// - interval code 1..9 gives 16..4096 ticks; 0 and 10..15 hold detector on
// - on-time code 0..9 gives 1..512 ticks; 10..15 give 1024 ticks
// - each interval starts with detector on for on-time, then off
// - writing the interval starts the first interval at the next tick
// - detector initialisation lead is taken from the preceding off time
// - carrier mode: detector off early once carrier evaluation finished
// - data mode: detector stays on until message end, error or timeout
// - on-time not below interval gives continuously-on operation
// - power-on and soft reset load interval code 0110
// - power-on and soft reset clear on-time code; register reads 0x60
// - mode bit: 0 data-receive, 1 carrier-detect
// - soft-reset bit starts receiver soft reset, self-clears, reads zero
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module lfds_scheduler (
  // clock and reset (reset acts as power-on reset)
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // detector events from the receive chain (same clock)
  input wire lfds_pkg::lfds_detect_type detectIn,
  // detector control
  output logic detectorOn,
  output logic detectorInit,
  output logic receiverEnable,
  output logic carrierModeSel,
  output logic receiverSoftResetPulse
);

  typedef struct packed {
    lfds_pkg::lfds_timing_type timing;
    logic enable;
    logic carrierMode;
    logic softReset;
    lfds_pkg::lfds_phase_type phase;
    logic [lfds_pkg::CNT_W-1:0] count;
    logic [lfds_pkg::CNT_W-1:0] holdTicks;
    logic startPending;
    logic detectorOn;
    logic detectorInit;
    logic [31:0] rdata;
  } lfds_state_type;

  lfds_state_type state_reg;
  lfds_state_type state_next;
  logic tick;
  logic [lfds_pkg::CNT_W-1:0] intervalTicks;
  logic [lfds_pkg::CNT_W-1:0] onTicks;
  logic continuous;
  logic writeAccess;
  logic readAccess;
  logic addrHit;

  lfds_osc_tick u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .tick(tick)
  );

  // decode of the timing codes into tick counts
  always_comb begin
    intervalTicks = '0;
    onTicks = '0;
    continuous = 1'b1;
    if (state_reg.timing.intervalSel >= lfds_pkg::INTERVAL_MIN_CODE &&
        state_reg.timing.intervalSel <= lfds_pkg::INTERVAL_MAX_CODE) begin
      intervalTicks = lfds_pkg::CNT_W'(1) << (state_reg.timing.intervalSel + 4'(lfds_pkg::INTERVAL_BASE_SHIFT));
      continuous = 1'b0;
    end
    if (state_reg.timing.onTimeSel >= lfds_pkg::ON_TIME_MAX_CODE) begin
      onTicks = lfds_pkg::CNT_W'(1) << lfds_pkg::ON_TIME_MAX_CODE;
    end else begin
      onTicks = lfds_pkg::CNT_W'(1) << state_reg.timing.onTimeSel;
    end
    if (onTicks >= intervalTicks) begin
      continuous = 1'b1;
    end
  end

  assign addrHit = (paddr == lfds_pkg::CTL1_ADDR) || (paddr == lfds_pkg::TIMING_ADDR) ||
                   (paddr == lfds_pkg::STATUS_ADDR);
  assign writeAccess = psel && penable && pwrite;
  assign readAccess = psel && !penable && !pwrite;

  always_comb begin
    state_next = state_reg;
    state_next.softReset = 1'b0;
    // register writes
    if (writeAccess && paddr == lfds_pkg::CTL1_ADDR) begin
      state_next.enable = pwdata[lfds_pkg::ENABLE_BIT];
      state_next.carrierMode = pwdata[lfds_pkg::CARRIER_MODE_BIT];
      state_next.softReset = pwdata[lfds_pkg::SOFT_RESET_BIT];
      if (pwdata[lfds_pkg::ENABLE_BIT] && !state_reg.enable) begin
        state_next.phase = lfds_pkg::LFDS_IDLE;
        state_next.startPending = 1'b1;
      end
    end
    if (writeAccess && paddr == lfds_pkg::TIMING_ADDR) begin
      state_next.timing = pwdata[7:0];
      state_next.phase = lfds_pkg::LFDS_IDLE;
      state_next.startPending = 1'b1;
    end
    // read data is captured in setup so it comes from flip-flops in the access phase
    if (readAccess) begin
      state_next.rdata = '0;
      case (paddr)
        lfds_pkg::CTL1_ADDR: begin
          state_next.rdata[lfds_pkg::ENABLE_BIT] = state_reg.enable;
          state_next.rdata[lfds_pkg::CARRIER_MODE_BIT] = state_reg.carrierMode; // reads back the stored mode bit
        end
        lfds_pkg::TIMING_ADDR: begin
          state_next.rdata[7:0] = state_reg.timing;
        end
        lfds_pkg::STATUS_ADDR: begin
          state_next.rdata[3:0] = {state_reg.detectorInit, state_reg.detectorOn, state_reg.phase};
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
    // scheduler
    if (!state_reg.enable) begin
      state_next.phase = lfds_pkg::LFDS_IDLE;
      state_next.count = '0;
      state_next.detectorOn = 1'b0;
      state_next.detectorInit = 1'b0;
      state_next.startPending = 1'b1;
    end else if (continuous) begin
      state_next.phase = lfds_pkg::LFDS_IDLE;
      state_next.count = '0;
      state_next.detectorOn = 1'b1;
      state_next.detectorInit = 1'b0;
      state_next.startPending = 1'b1;
    end else if (writeAccess && paddr == lfds_pkg::TIMING_ADDR) begin
      // a write that meets a tick must not open a window on that same tick
      state_next.phase = lfds_pkg::LFDS_IDLE;
      state_next.count = '0;
      state_next.detectorOn = 1'b0;
      state_next.detectorInit = 1'b1;
      state_next.startPending = 1'b1;
    end else begin
      case (state_reg.phase)
        lfds_pkg::LFDS_IDLE: begin
          state_next.detectorOn = 1'b0;
          state_next.detectorInit = 1'b1;
          if (tick && state_reg.startPending) begin
            state_next.phase = lfds_pkg::LFDS_ON;
            state_next.count = '0;
            state_next.startPending = 1'b0;
            state_next.detectorOn = 1'b1;
            state_next.detectorInit = 1'b0;
          end
        end
        lfds_pkg::LFDS_ON: begin
          state_next.detectorOn = 1'b1;
          if (tick) begin
            state_next.count = state_reg.count + lfds_pkg::CNT_W'(1);
          end
          if (state_reg.carrierMode && detectIn.signalDetected && detectIn.carrierEvalDone) begin
            state_next.phase = lfds_pkg::LFDS_OFF;
            state_next.detectorOn = 1'b0;
          end else if (tick && state_reg.count + lfds_pkg::CNT_W'(1) >= onTicks) begin
            if (!state_reg.carrierMode && detectIn.signalDetected) begin
              state_next.phase = lfds_pkg::LFDS_HOLD;
              state_next.holdTicks = '0;
            end else begin
              state_next.phase = lfds_pkg::LFDS_OFF;
              state_next.detectorOn = 1'b0;
            end
          end
        end
        lfds_pkg::LFDS_HOLD: begin
          // interval keeps counting, wrapping at its end, so the schedule stays aligned after the message
          if (tick) begin
            state_next.count = state_reg.count + lfds_pkg::CNT_W'(1);
            state_next.holdTicks = state_reg.holdTicks + lfds_pkg::CNT_W'(1);
            if (state_reg.count + lfds_pkg::CNT_W'(1) >= intervalTicks) begin
              state_next.count = '0;
            end
          end
          // a lost signal counts as a receive error; the hold timeout bounds a stuck message
          if (detectIn.messageDone || !detectIn.signalDetected ||
              (tick && state_reg.holdTicks + lfds_pkg::CNT_W'(1) >= lfds_pkg::CNT_W'(lfds_pkg::HOLD_TIMEOUT_TICKS))) begin
            state_next.phase = lfds_pkg::LFDS_OFF;
            state_next.detectorOn = 1'b0;
          end
        end
        lfds_pkg::LFDS_OFF: begin
          state_next.detectorOn = 1'b0;
          if (tick) begin
            state_next.count = state_reg.count + lfds_pkg::CNT_W'(1);
          end
          // initialisation lead sits at the end of the off time
          state_next.detectorInit = (state_reg.count + lfds_pkg::CNT_W'(lfds_pkg::INIT_TICKS) >= intervalTicks);
          if (tick && state_reg.count + lfds_pkg::CNT_W'(1) >= intervalTicks) begin
            state_next.phase = lfds_pkg::LFDS_ON;
            state_next.count = '0;
            state_next.detectorOn = 1'b1;
            state_next.detectorInit = 1'b0;
          end
        end
        default: begin
          state_next.phase = lfds_pkg::LFDS_IDLE;
        end
      endcase
    end
    // soft reset reloads the timing register, clears the control bits and stops the schedule
    if (state_reg.softReset) begin
      state_next.timing = {lfds_pkg::INTERVAL_RESET, lfds_pkg::ON_TIME_RESET};
      state_next.enable = 1'b0;
      state_next.carrierMode = 1'b0;
      state_next.phase = lfds_pkg::LFDS_IDLE;
      state_next.count = '0;
      state_next.startPending = 1'b1;
      state_next.detectorOn = 1'b0;
      state_next.detectorInit = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.timing <= lfds_pkg::TIMING_RESET;
      state_reg.startPending <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;
  assign detectorOn = state_reg.detectorOn;
  assign detectorInit = state_reg.detectorInit;
  assign receiverEnable = state_reg.enable;
  assign carrierModeSel = state_reg.carrierMode;
  assign receiverSoftResetPulse = state_reg.softReset;

endmodule
`default_nettype wire

// >>> lfds_pkg.sv
// package: register map, field layout, reset values and types of the duty-cycle scheduler
package lfds_pkg;

  // register byte addresses (printed offset 0x21 is not a multiple of four, so offsets 0x20, 0x21 are indexes: index * 4)
  localparam logic [7:0] CTL1_INDEX = 8'h20;
  localparam logic [7:0] TIMING_INDEX = 8'h21;
  localparam logic [11:0] CTL1_ADDR = {2'h0, CTL1_INDEX, 2'h0};
  localparam logic [11:0] TIMING_ADDR = {2'h0, TIMING_INDEX, 2'h0};
  localparam logic [11:0] STATUS_ADDR = 12'h090;

  // timing register fields
  localparam int INTERVAL_LSB = 4;
  localparam int ON_TIME_LSB = 0;
  localparam logic [7:0] TIMING_RESET = 8'h60;
  localparam logic [3:0] INTERVAL_RESET = 4'h6;
  localparam logic [3:0] ON_TIME_RESET = 4'h0;

  // control register fields
  localparam int ENABLE_BIT = 7;
  localparam int SOFT_RESET_BIT = 6;
  localparam int CARRIER_MODE_BIT = 5;

  // interval codes that give a duty cycle; others mean continuously on
  localparam logic [3:0] INTERVAL_MIN_CODE = 4'h1;
  localparam logic [3:0] INTERVAL_MAX_CODE = 4'h9;
  localparam logic [3:0] ON_TIME_MAX_CODE = 4'hA;
  localparam int INTERVAL_BASE_SHIFT = 3;

  // low-power oscillator tick: nominal period 1 ms at a 40 MHz core clock
  localparam int CORE_CLK_KHZ = 40000;
  localparam int OSC_PERIOD_US = 1000;
  localparam int OSC_TICK_CYCLES = CORE_CLK_KHZ * OSC_PERIOD_US / 1000;

  // detector initialisation lead, taken from the off time
  localparam int INIT_TIME_US = 2000;
  localparam int INIT_TICKS = (INIT_TIME_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;

  // longest detector hold while a message is being received
  localparam int HOLD_TIMEOUT_TICKS = 256;

  localparam int CNT_W = 13;

  typedef enum logic [1:0] {
    LFDS_IDLE = 2'b00,
    LFDS_ON = 2'b01,
    LFDS_HOLD = 2'b11,
    LFDS_OFF = 2'b10
  } lfds_phase_type;

  typedef struct packed {
    logic [3:0] intervalSel;
    logic [3:0] onTimeSel;
  } lfds_timing_type;

  typedef struct packed {
    logic signalDetected;
    logic carrierEvalDone;
    logic messageDone;
  } lfds_detect_type;

endpackage

// >>> lfds_osc_tick.sv
// module: divider producing the low-power oscillator tick enable
`timescale 1ns/100ps
`default_nettype none
module lfds_osc_tick (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // tick output
  output logic tick
);

  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } lfds_tick_state_type;

  lfds_tick_state_type state_reg;
  lfds_tick_state_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.count == 16'(lfds_pkg::OSC_TICK_CYCLES - 1)) begin
      state_next.count = 16'h0000;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule
`default_nettype wire

// >>> lfds_scheduler_properties.sv
// checker: port-level properties of the duty-cycle scheduler
`timescale 1ns/100ps
`default_nettype none
module lfds_scheduler_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // detector side
  input wire lfds_pkg::lfds_detect_type detectIn,
  input wire logic detectorOn,
  input wire logic detectorInit,
  input wire logic receiverEnable,
  input wire logic carrierModeSel,
  input wire logic receiverSoftResetPulse
);
  logic ctlWr;
  logic mapped;
  assign ctlWr = psel && penable && pwrite && paddr == lfds_pkg::CTL1_ADDR;
  assign mapped = paddr inside {lfds_pkg::CTL1_ADDR, lfds_pkg::TIMING_ADDR, lfds_pkg::STATUS_ADDR};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_zero_wait; psel && penable |-> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access without pready");
  property p_unmapped; psel && penable && !mapped |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_soft_pulse; ctlWr && pwdata[6] |=> receiverSoftResetPulse ##1 !receiverSoftResetPulse; endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse wrong");
  property p_soft_reads_zero; psel && penable && !pwrite && paddr == lfds_pkg::CTL1_ADDR |-> !prdata[6]; endproperty
  a_soft_reads_zero: assert property (p_soft_reads_zero) else $error("soft reset bit read as one");
  property p_enable; ctlWr && pwdata[7] && !pwdata[6] |=> receiverEnable; endproperty
  a_enable: assert property (p_enable) else $error("enable not taken");
  property p_mode; ctlWr && pwdata[5] && !pwdata[6] |=> carrierModeSel; endproperty
  a_mode: assert property (p_mode) else $error("carrier mode not taken");
  property p_disabled_off; !receiverEnable [*3] |-> !detectorOn; endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("detector on while disabled");
  property p_carrier_early;
    carrierModeSel && detectorOn && detectIn.signalDetected && detectIn.carrierEvalDone && !psel |=> !detectorOn;
  endproperty
  a_carrier_early: assert property (p_carrier_early) else $error("detector kept on after evaluation");
  property p_data_hold;
    !carrierModeSel && receiverEnable && detectorOn && detectIn.signalDetected && !detectIn.messageDone && !psel
      && !receiverSoftResetPulse |=> detectorOn;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("detector dropped during message");
  property p_init_apart; detectorInit |-> !detectorOn; endproperty
  a_init_apart: assert property (p_init_apart) else $error("init lead overlaps on window");
  c_carrier: cover property (carrierModeSel && detectorOn && detectIn.carrierEvalDone);
  c_message: cover property (detectIn.messageDone);
  c_rise: cover property ($rose(detectorOn));
endmodule
bind lfds_scheduler lfds_scheduler_properties u_props (.core_clk(core_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .detectIn(detectIn), .detectorOn(detectorOn), .detectorInit(detectorInit),
  .receiverEnable(receiverEnable), .carrierModeSel(carrierModeSel), .receiverSoftResetPulse(receiverSoftResetPulse));
`default_nettype wire

// >>> lfds_rx_model.sv
// partner: behavioural receive chain reacting while the detector is powered
`timescale 1ns/100ps
`default_nettype none
module lfds_rx_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // scenario control
  input wire logic carrierPresent,
  input wire logic messageEnd,
  // detector link
  input wire logic detectorOn,
  output var lfds_pkg::lfds_detect_type detectOut
);
  // an unpowered chain sees nothing, so every flag drops with the detector
  always_ff @(posedge core_clk) begin
    if (reset || !detectorOn) begin
      detectOut <= '0;
    end else begin
      detectOut.signalDetected <= carrierPresent;
      detectOut.carrierEvalDone <= detectOut.signalDetected;
      detectOut.messageDone <= messageEnd && detectOut.signalDetected;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// testbench: apb-driven scenarios for the duty-cycle scheduler
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic carrierPresent = 1'b0;
  logic messageEnd = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, detectorOn, detectorInit, receiverEnable, carrierModeSel, softPulse, err;
  lfds_pkg::lfds_detect_type detectIn;
  logic [7:0] codes [7] = '{8'h00, 8'hA0, 8'hF0, 8'h1A, 8'h14, 8'h13, 8'h90};
  logic expOn [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int bad_count = 0;
  int compares = 0;
  int n;
  lfds_scheduler DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .detectIn(detectIn),
    .detectorOn(detectorOn), .detectorInit(detectorInit), .receiverEnable(receiverEnable),
    .carrierModeSel(carrierModeSel), .receiverSoftResetPulse(softPulse));
  lfds_rx_model rx (.core_clk(core_clk), .reset(reset), .carrierPresent(carrierPresent),
    .messageEnd(messageEnd), .detectorOn(detectorOn), .detectOut(detectIn));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rdat, exp, "register read");
  endtask
  // sampled on the falling edge so register updates have landed
  task automatic waitOn(input logic lvl, input int lim);
    n = 0;
    while (detectorOn !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(lfds_pkg::TIMING_ADDR, 32'h60);
    rd(lfds_pkg::CTL1_ADDR, 32'h0);
    xfer(12'h0A0, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped refused");
    xfer(lfds_pkg::TIMING_ADDR, 1'b1, 32'h35);
    rd(lfds_pkg::TIMING_ADDR, 32'h35);
    xfer(lfds_pkg::CTL1_ADDR, 1'b1, 32'hE0);
    @(negedge core_clk);
    chk({31'h0, softPulse}, 32'h1, "soft reset pulse");
    rd(lfds_pkg::TIMING_ADDR, 32'h60);
    rd(lfds_pkg::CTL1_ADDR, 32'h0);
    for (int i = 0; i < 7; i++) begin
      xfer(lfds_pkg::TIMING_ADDR, 1'b1, {24'h0, codes[i]});
      xfer(lfds_pkg::CTL1_ADDR, 1'b1, 32'h80);
      repeat (3) @(negedge core_clk);
      chk({31'h0, detectorOn}, {31'h0, expOn[i]}, "continuous on");
      xfer(lfds_pkg::CTL1_ADDR, 1'b1, 32'h0);
      repeat (3) @(negedge core_clk);
      chk({31'h0, detectorOn}, 32'h0, "off when disabled");
    end
    // carrier mode: one tick on-time, carrier arrives mid-window
    xfer(lfds_pkg::TIMING_ADDR, 1'b1, 32'h10);
    xfer(lfds_pkg::CTL1_ADDR, 1'b1, 32'hA0);
    repeat (2) @(negedge core_clk);
    chk({30'h0, receiverEnable, carrierModeSel}, 32'h3, "enable and carrier mode");
    chk({31'h0, detectorInit}, 32'h1, "init lead before first window");
    waitOn(1'b1, 41000);
    chk({31'h0, n <= 40002}, 32'h1, "first window late");
    chk({31'h0, detectorInit}, 32'h0, "init lead inside window");
    rd(lfds_pkg::STATUS_ADDR, 32'h5);
    @(posedge core_clk);
    carrierPresent <= 1'b1;
    waitOn(1'b0, 8);
    chk({31'h0, detectorOn}, 32'h0, "carrier early off");
    @(posedge core_clk);
    carrierPresent <= 1'b0;
    // data mode: message outlives the scheduled on-time
    xfer(lfds_pkg::CTL1_ADDR, 1'b1, 32'h0);
    xfer(lfds_pkg::CTL1_ADDR, 1'b1, 32'h80);
    waitOn(1'b1, 41000);
    repeat (39000) @(negedge core_clk);
    chk({31'h0, detectorOn}, 32'h1, "on window short");
    @(posedge core_clk);
    carrierPresent <= 1'b1;
    repeat (1100) @(negedge core_clk);
    chk({31'h0, detectorOn}, 32'h1, "data hold");
    @(posedge core_clk);
    messageEnd <= 1'b1;
    @(posedge core_clk);
    messageEnd <= 1'b0;
    carrierPresent <= 1'b0;
    waitOn(1'b0, 8);
    chk({31'h0, detectorOn}, 32'h0, "message end off");
    conclude();
  end
  initial begin
    repeat (135000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
